// ---- hdl/sqe_entry_reg.sv ----
// One sequence stack entry register with address-qualified writes.
module sqe_entry_reg #(
	parameter logic [5:0]  ENTRY_ADDR = 6'h2A,
	parameter logic [15:0] RST_VALUE  = 16'h5400
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] entry_q
);

	typedef struct packed {
		logic [15:0] word;
	} sqe_entry_s;

	sqe_entry_s s_q;
	sqe_entry_s s_d;
	logic       addr_hit;

	// A write lands only when it carries this entry's own address in the address field.
	assign addr_hit = wr_data[sqe_pkg::ADDR_MSB:sqe_pkg::ADDR_LSB] == ENTRY_ADDR;

	// Next value: direction, return control and both channel picks follow the write.
	always_comb begin
		s_d = s_q;
		if (wr_en && addr_hit) begin
			s_d.word = wr_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q.word <= RST_VALUE;
		end else begin
			s_q <= s_d;
		end
	end

	assign entry_q = s_q.word;

	a_addr_kept: assert property (@(posedge clk) disable iff (!resetn)
		entry_q[sqe_pkg::ADDR_MSB:sqe_pkg::ADDR_LSB] == ENTRY_ADDR)
		else $error("entry address field lost its own address");

	a_write_taken: assert property (@(posedge clk) disable iff (!resetn)
		wr_en && addr_hit |=> entry_q[sqe_pkg::DIR_BIT] == $past(wr_data[sqe_pkg::DIR_BIT])
			&& entry_q == $past(wr_data))
		else $error("accepted entry write not stored");

	a_write_refused: assert property (@(posedge clk) disable iff (!resetn)
		wr_en && !addr_hit |=> $stable(entry_q))
		else $error("write with foreign address changed the entry");

endmodule : sqe_entry_reg

// ---- hdl/sqe_seq_walk.sv ----
// Walker that steps through the stack entries and drives the converter channel picks.
module sqe_seq_walk #(
	parameter int NUM = 4
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   enable,
	input  wire logic                   conv_start,
	input  wire logic                   conv_done,
	input  wire logic [15:0]            entry_word,
	output logic      [$clog2(NUM)-1:0] active_entry,
	output logic      [3:0]             converter_a_channel_pick,
	output logic      [3:0]             converter_b_channel_pick,
	output logic                        entry_dir,
	output logic                        stack_return,
	output logic                        seq_busy
);

	localparam int IW = $clog2(NUM);
	localparam logic [IW-1:0] LAST = IW'(NUM - 1);

	typedef struct packed {
		sqe_pkg::sqe_walk_e state;
		logic [IW-1:0]      idx;
		logic [3:0]         chan_a;
		logic [3:0]         chan_b;
		logic               dir;
		logic               ret;
		logic               ret_pulse;
	} sqe_walk_s;

	sqe_walk_s s_q;
	sqe_walk_s s_d;

	// Picks are latched at conversion start so a register write mid-conversion cannot disturb it.
	always_comb begin
		s_d = s_q;
		s_d.ret_pulse = 1'b0;
		if (!enable) begin
			s_d.state = sqe_pkg::SQE_IDLE;
			s_d.idx   = '0;
		end else begin
			unique case (s_q.state)
				sqe_pkg::SQE_IDLE: begin
					s_d.state = sqe_pkg::SQE_ARMED;
				end
				sqe_pkg::SQE_ARMED: begin
					if (conv_start) begin
						s_d.chan_b = entry_word[sqe_pkg::CHB_MSB:sqe_pkg::CHB_LSB];
						s_d.chan_a = entry_word[sqe_pkg::CHA_MSB:sqe_pkg::CHA_LSB];
						s_d.dir    = entry_word[sqe_pkg::DIR_BIT];
						s_d.ret    = entry_word[sqe_pkg::RET_BIT];
						s_d.state  = sqe_pkg::SQE_CONVERTING;
					end
				end
				sqe_pkg::SQE_CONVERTING: begin
					// The return bit is only looked at once the conversion is over.
					if (conv_done) begin
						s_d.state = sqe_pkg::SQE_ARMED;
						if (s_q.ret) begin
							s_d.idx       = '0;
							s_d.ret_pulse = 1'b1;
						end else begin
							s_d.idx = (s_q.idx == LAST) ? '0 : s_q.idx + 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{sqe_pkg::SQE_IDLE, '0, sqe_pkg::RST_CHANNEL, sqe_pkg::RST_CHANNEL, 1'b0, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign active_entry             = s_q.idx;
	assign converter_a_channel_pick = s_q.chan_a;
	assign converter_b_channel_pick = s_q.chan_b;
	assign entry_dir                = s_q.dir;
	assign stack_return             = s_q.ret_pulse;
	assign seq_busy                 = s_q.state == sqe_pkg::SQE_CONVERTING;

	sequence s_start_taken;
		enable && s_q.state == sqe_pkg::SQE_ARMED && conv_start;
	endsequence

	sequence s_done_taken;
		enable && s_q.state == sqe_pkg::SQE_CONVERTING && conv_done;
	endsequence

	a_chan_b_apply: assert property (@(posedge clk) disable iff (!resetn)
		s_start_taken |=> converter_b_channel_pick == $past(entry_word[7:4]) && seq_busy)
		else $error("converter B pick not applied at conversion start");

	a_chan_a_apply: assert property (@(posedge clk) disable iff (!resetn)
		s_start_taken |=> converter_a_channel_pick == $past(entry_word[3:0]))
		else $error("converter A pick not applied at conversion start");

	a_return_first: assert property (@(posedge clk) disable iff (!resetn)
		s_done_taken ##0 s_q.ret |=> active_entry == '0 && stack_return ##1 !stack_return)
		else $error("return control did not go back to the first entry");

	a_advance_next: assert property (@(posedge clk) disable iff (!resetn)
		s_done_taken ##0 !s_q.ret && s_q.idx != LAST |=> active_entry == $past(active_entry) + 1'b1)
		else $error("sequencer did not advance to the next entry");

	a_return_after: assert property (@(posedge clk) disable iff (!resetn)
		stack_return |-> $past(seq_busy) && $past(conv_done) && !seq_busy)
		else $error("return evaluated before the conversion completed");

endmodule : sqe_seq_walk

// ---- hdl/sqe_stack_regs.sv ----
// AHB-Lite register slice for sequence stack entries ten to thirteen with its entry walker.
module sqe_stack_regs (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        conv_start,
	input  wire logic        conv_done,
	output logic      [3:0]  converter_a_channel_pick,
	output logic      [3:0]  converter_b_channel_pick,
	output logic             entry_dir,
	output logic             stack_return,
	output logic      [1:0]  active_entry,
	output logic             seq_busy
);

	// ****************************************************************
	// Bus state
	// ****************************************************************

	// Map: entries ten to thirteen at indices 0x2A to 0x2D, status at 0x30, control at 0x31.
	// The byte address is four times the index; anything above the low byte is unmapped.
	// Writes complete with no wait state and land at the end of their data phase.
	// Reads always take exactly one wait state, in which the word is captured, so the
	// value returned is the one that stood one edge after the address was taken.
	// Limitation: the transfer size is not checked; only whole aligned words are expected.
	// Limitation: the response is always OKAY, even for unmapped or refused writes.
	// Trade-off: the extra read cycle keeps the read multiplexer off the bus output path.
	typedef struct packed {
		logic        wr_pend;
		logic        rd_pend;
		logic [5:0]  idx;
		logic [31:0] rdata;
		logic        seq_enable;
	} sqe_bus_s;

	localparam int NE = sqe_pkg::NUM_ENTRIES;

	sqe_bus_s    s_q;
	sqe_bus_s    s_d;
	logic        addr_phase;
	logic [5:0]  addr_idx;
	logic [31:0] rd_word;
	logic [15:0] entry_q [NE];
	logic [NE-1:0] entry_wr;
	logic [15:0] active_word;
	logic [31:0] status_word;

	// A transfer is taken only on a valid NONSEQ or SEQ with the bus ready.
	assign addr_phase = hsel && htrans[1] && hready;

	// Addresses above the low byte are unmapped; they fold onto an index that decodes to nothing.
	assign addr_idx = (haddr[31:8] == 24'h000000) ? haddr[7:2] : sqe_pkg::IDX_NONE;

	// ****************************************************************
	// Read multiplexer
	// ****************************************************************

	// Status shows the walker's own position and whether a conversion is in flight.
	assign status_word = {27'h0000000, seq_busy, 2'h0, active_entry};

	// Unmapped indices read as zero; entries sit in the low half-word.
	always_comb begin
		unique case (s_q.idx)
			sqe_pkg::IDX_ENTRY_10: rd_word = {16'h0000, entry_q[0]};
			sqe_pkg::IDX_ENTRY_11: rd_word = {16'h0000, entry_q[1]};
			sqe_pkg::IDX_ENTRY_12: rd_word = {16'h0000, entry_q[2]};
			sqe_pkg::IDX_ENTRY_13: rd_word = {16'h0000, entry_q[3]};
			sqe_pkg::IDX_STATUS:   rd_word = status_word;
			sqe_pkg::IDX_CONTROL:  rd_word = {31'h00000000, s_q.seq_enable};
			default:               rd_word = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// Bus sequencing
	// ****************************************************************

	// Reads take one wait state: the data are captured a cycle after a preceding
	// write's data phase, so a read right behind a write always sees the new value.
	always_comb begin
		s_d = s_q;
		s_d.wr_pend = 1'b0;
		if (s_q.rd_pend) begin
			s_d.rd_pend = 1'b0;
			s_d.rdata   = rd_word;
		end
		if (s_q.wr_pend && s_q.idx == sqe_pkg::IDX_CONTROL) begin
			s_d.seq_enable = hwdata[sqe_pkg::CTRL_ENABLE_BIT];
		end
		if (addr_phase) begin
			s_d.idx     = addr_idx;
			s_d.wr_pend = hwrite;
			s_d.rd_pend = !hwrite;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{1'b0, 1'b0, sqe_pkg::IDX_NONE, 32'h00000000, sqe_pkg::RST_ENABLE};
		end else begin
			s_q <= s_d;
		end
	end

	// Only whole-word single transfers are expected; the response is always OKAY.
	assign hreadyout = !s_q.rd_pend;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;

	// ****************************************************************
	// Stack entries
	// ****************************************************************

	// One register per entry; each decodes its own index and keeps its own address.
	for (genvar i = 0; i < NE; i++) begin : g_entry
		localparam logic [5:0]  EIDX = sqe_pkg::IDX_ENTRY_10 + 6'(i);
		localparam logic [15:0] ERST = sqe_pkg::RST_ENTRY_10 + 16'(i * 16'h0200);

		assign entry_wr[i] = s_q.wr_pend && s_q.idx == EIDX;

		sqe_entry_reg #(
			.ENTRY_ADDR (EIDX),
			.RST_VALUE  (ERST)
		) u_entry (
			.clk     (clk),
			.resetn  (resetn),
			.wr_en   (entry_wr[i]),
			.wr_data (hwdata[15:0]),
			.entry_q (entry_q[i])
		);
	end

	// ****************************************************************
	// Entry walker
	// ****************************************************************

	// The walker sees only the entry it currently points at.
	assign active_word = entry_q[active_entry];

	sqe_seq_walk #(
		.NUM (NE)
	) u_walk (
		.clk                      (clk),
		.resetn                   (resetn),
		.enable                   (s_q.seq_enable),
		.conv_start               (conv_start),
		.conv_done                (conv_done),
		.entry_word               (active_word),
		.active_entry             (active_entry),
		.converter_a_channel_pick (converter_a_channel_pick),
		.converter_b_channel_pick (converter_b_channel_pick),
		.entry_dir                (entry_dir),
		.stack_return             (stack_return),
		.seq_busy                 (seq_busy)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************

	a_entry10_reset: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> entry_q[0] == 16'h5400)
		else $error("entry ten reset value wrong");

	a_entry11_reset: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> entry_q[1] == 16'h5600 && entry_q[1][14:9] == 6'b101011)
		else $error("entry eleven reset value wrong");

	a_entry12_reset: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> entry_q[2] == 16'h5800 && entry_q[2][14:9] == 6'b101100)
		else $error("entry twelve reset value wrong");

	a_entry13_reset: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> entry_q[3] == 16'h5A00)
		else $error("entry thirteen reset value wrong");

	sequence s_read_e10;
		addr_phase && !hwrite && haddr == 32'h000000A8;
	endsequence

	a_read_entry10: assert property (@(posedge clk) disable iff (!resetn)
		s_read_e10 |=> !hreadyout ##1 hreadyout && hrdata == {16'h0000, $past(entry_q[0])})
		else $error("read of entry ten at byte 0xA8 returned wrong data");

	a_read_wait: assert property (@(posedge clk) disable iff (!resetn)
		addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state not exactly one cycle");

	a_write_entry13: assert property (@(posedge clk) disable iff (!resetn)
		addr_phase && hwrite && haddr == 32'h000000B4 ##1 hwdata[14:9] == 6'b101101
			|=> entry_q[3] == $past(hwdata[15:0]))
		else $error("write to entry thirteen at byte 0xB4 not stored");

	// A write that names the entry in its address phase and carries the entry's own index
	// in bits 14 to 9 of its data phase; the entry must hold the word one edge later.
	sequence s_own_write(logic [5:0] eidx);
		addr_phase && hwrite && addr_idx == eidx ##1 hwdata[sqe_pkg::ADDR_MSB:sqe_pkg::ADDR_LSB] == eidx;
	endsequence

	a_write_entry10: assert property (@(posedge clk) disable iff (!resetn)
		s_own_write(sqe_pkg::IDX_ENTRY_10) |=> entry_q[0] == $past(hwdata[15:0]))
		else $error("write to entry ten not stored");

	a_write_entry11: assert property (@(posedge clk) disable iff (!resetn)
		s_own_write(sqe_pkg::IDX_ENTRY_11) |=> entry_q[1] == $past(hwdata[15:0]))
		else $error("write to entry eleven not stored");

	a_write_entry12: assert property (@(posedge clk) disable iff (!resetn)
		s_own_write(sqe_pkg::IDX_ENTRY_12) |=> entry_q[2] == $past(hwdata[15:0]))
		else $error("write to entry twelve not stored");

	// Entry thirteen reads back its stored word with the upper half clear.
	a_read_entry13: assert property (@(posedge clk) disable iff (!resetn)
		s_q.rd_pend && s_q.idx == sqe_pkg::IDX_ENTRY_13 |=> hrdata == {16'h0000, $past(entry_q[3])})
		else $error("read of entry thirteen returned wrong data");

	// A word that carries another entry's address must leave entry eleven untouched.
	a_foreign_write: assert property (@(posedge clk) disable iff (!resetn)
		addr_phase && hwrite && addr_idx == sqe_pkg::IDX_ENTRY_11
			##1 hwdata[sqe_pkg::ADDR_MSB:sqe_pkg::ADDR_LSB] != sqe_pkg::IDX_ENTRY_11 |=> $stable(entry_q[1]))
		else $error("write with foreign address changed entry eleven");

	// ****************************************************************
	// Bus protocol checks
	// ****************************************************************

	// Writes never stall the bus: the data phase always completes at once.
	a_write_no_wait: assert property (@(posedge clk) disable iff (!resetn)
		addr_phase && hwrite |=> hreadyout)
		else $error("write data phase was stretched");

	// Read data stand until the next read captures a new word.
	a_hrdata_hold: assert property (@(posedge clk) disable iff (!resetn)
		!s_q.rd_pend |=> $stable(hrdata))
		else $error("read data changed without a read");

	// Entries are half-words; the upper half of their read word is always clear.
	a_entry_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
		s_q.rd_pend && s_q.idx >= sqe_pkg::IDX_ENTRY_10 && s_q.idx <= sqe_pkg::IDX_ENTRY_13
		|=> hrdata[31:16] == 16'h0000)
		else $error("entry read with upper half set");

	// Indices outside the map must read as zero so software never sees stale capture data.
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
		s_q.rd_pend && (s_q.idx < sqe_pkg::IDX_ENTRY_10 || s_q.idx > sqe_pkg::IDX_CONTROL
			|| (s_q.idx > sqe_pkg::IDX_ENTRY_13 && s_q.idx < sqe_pkg::IDX_STATUS))
		|=> hrdata == 32'h00000000)
		else $error("unmapped index did not read as zero");

	// Status reports the walker as it stood when the read data were captured.
	a_status_read: assert property (@(posedge clk) disable iff (!resetn)
		s_q.rd_pend && s_q.idx == sqe_pkg::IDX_STATUS
		|=> hrdata[sqe_pkg::STAT_BUSY_BIT] == $past(seq_busy)
			&& hrdata[sqe_pkg::STAT_IDX_MSB:0] == $past(active_entry))
		else $error("status read does not match the walker");

	// The enable bit follows the data phase of a control write.
	a_control_write: assert property (@(posedge clk) disable iff (!resetn)
		s_q.wr_pend && s_q.idx == sqe_pkg::IDX_CONTROL
		|=> s_q.seq_enable == $past(hwdata[sqe_pkg::CTRL_ENABLE_BIT]))
		else $error("control write not stored");

	// ****************************************************************
	// Walker checks
	// ****************************************************************

	// Clearing the enable parks the walker on entry ten; a half-finished conversion is dropped.
	a_disable_home: assert property (@(posedge clk) disable iff (!resetn)
		!s_q.seq_enable |=> active_entry == 2'h0 && !seq_busy)
		else $error("disabled walker not parked on entry ten");

	// A start pulse while the walker is disabled must not begin a conversion.
	a_start_refused: assert property (@(posedge clk) disable iff (!resetn)
		!s_q.seq_enable && conv_start |=> !seq_busy)
		else $error("conversion started while disabled");

	// Register writes during a conversion must not disturb the picks already applied.
	a_picks_held: assert property (@(posedge clk) disable iff (!resetn)
		seq_busy |=> $stable(converter_a_channel_pick) && $stable(converter_b_channel_pick)
			&& $stable(entry_dir))
		else $error("picks changed during a conversion");

endmodule : sqe_stack_regs

// ---- pkg/sqe_pkg.sv ----
// Constants and types shared by the sequence stack entry register slice.
package sqe_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [5:0] IDX_ENTRY_10 = 6'h2A;
	localparam logic [5:0] IDX_ENTRY_11 = 6'h2B;
	localparam logic [5:0] IDX_ENTRY_12 = 6'h2C;
	localparam logic [5:0] IDX_ENTRY_13 = 6'h2D;
	localparam logic [5:0] IDX_STATUS   = 6'h30;
	localparam logic [5:0] IDX_CONTROL  = 6'h31;
	localparam logic [5:0] IDX_NONE     = 6'h00;
	localparam int         NUM_ENTRIES  = 4;

	// ****************************************************************
	// Entry word field layout
	// ****************************************************************
	localparam int DIR_BIT  = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 9;
	localparam int RET_BIT  = 8;
	localparam int CHB_MSB  = 7;
	localparam int CHB_LSB  = 4;
	localparam int CHA_MSB  = 3;
	localparam int CHA_LSB  = 0;

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic [15:0] RST_ENTRY_10 = 16'h5400;
	localparam logic [15:0] RST_ENTRY_11 = 16'h5600;
	localparam logic [15:0] RST_ENTRY_12 = 16'h5800;
	localparam logic [15:0] RST_ENTRY_13 = 16'h5A00;
	localparam logic        RST_ENABLE   = 1'h0;
	localparam logic [3:0]  RST_CHANNEL  = 4'h0;

	// ****************************************************************
	// Control and status bit positions
	// ****************************************************************
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STAT_BUSY_BIT   = 4;
	localparam int STAT_IDX_MSB    = 1;

	// Sequencer walk states.
	typedef enum logic [1:0] {
		SQE_IDLE,
		SQE_ARMED,
		SQE_CONVERTING
	} sqe_walk_e;

endpackage : sqe_pkg

// ---- tb/sqe_host_model.sv ----
// AHB-Lite master model that stands in for the host controller.
module sqe_host_model (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Bus idle values
	// ****************************************************************
	// The bus starts idle so no transfer is seen while reset is held.
	initial begin
		hsel = 1'h0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end

	// ****************************************************************
	// Host helpers
	// ****************************************************************
	// The host must put the entry's own address in the word, or the write is lost.
	function automatic logic [15:0] entry_word(input logic dir, input logic [5:0] idx, input logic ret,
			input logic [3:0] chb, input logic [3:0] cha);
		return {dir, idx, ret, chb, cha};
	endfunction : entry_word

	// One single word transfer; waits on hready without assuming any latency.
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= {24'h000000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
		// Released lines carry the inverse, so stale values never pass as valid.
		haddr <= ~haddr;
		hwdata <= ~wd;
	endtask : xfer

endmodule : sqe_host_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the sequence stack entry register slice.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        resetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        conv_start;
	logic        conv_done;
	logic [3:0]  pick_a;
	logic [3:0]  pick_b;
	logic        entry_dir;
	logic        stack_return;
	logic [1:0]  active_entry;
	logic        seq_busy;
	logic [31:0] rd;
	logic [15:0] exp_e [4];
	int          fail_count;
	int          checked;

	// ****************************************************************
	// Clock, design and host
	// ****************************************************************
	// A 40 ns period gives the 25 MHz clock.
	always #20 clk = ~clk;

	sqe_stack_regs u_sqe_stack_regs (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_start(conv_start),
		.conv_done(conv_done), .converter_a_channel_pick(pick_a), .converter_b_channel_pick(pick_b),
		.entry_dir(entry_dir), .stack_return(stack_return), .active_entry(active_entry),
		.seq_busy(seq_busy));

	sqe_host_model u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// Counts every compare and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		u_host.xfer(1'h0, idx, 32'h00000000, v);
		chk(what, exp, v);
		chk("hresp", 32'h00000000, {31'h0, hresp});
	endtask : rd_chk

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		u_host.xfer(1'h1, idx, d, rd);
	endtask : wr

	// One conversion: start, then done a cycle later, as fast as the walker allows.
	task automatic conv_step(input logic [15:0] w, input logic [1:0] cur, input logic [1:0] nxt);
		@(posedge clk);
		conv_start <= 1'h1;
		@(posedge clk);
		conv_start <= 1'h0;
		conv_done <= 1'h1;
		#1;
		chk("pick_a", {28'h0, w[3:0]}, {28'h0, pick_a});
		chk("pick_b", {28'h0, w[7:4]}, {28'h0, pick_b});
		chk("entry_dir", {31'h0, w[15]}, {31'h0, entry_dir});
		chk("active_hold", {30'h0, cur}, {30'h0, active_entry});
		chk("busy_on", 32'h1, {31'h0, seq_busy});
		@(posedge clk);
		conv_done <= 1'h0;
		#1;
		chk("busy_off", 32'h0, {31'h0, seq_busy});
		chk("active_entry", {30'h0, nxt}, {30'h0, active_entry});
		chk("stack_return", {31'h0, w[8]}, {31'h0, stack_return});
	endtask : conv_step

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset_values();
		rd_chk("entry10_rst", sqe_pkg::IDX_ENTRY_10, 32'h00005400);
		rd_chk("entry11_rst", sqe_pkg::IDX_ENTRY_11, 32'h00005600);
		rd_chk("entry12_rst", sqe_pkg::IDX_ENTRY_12, 32'h00005800);
		rd_chk("entry13_rst", sqe_pkg::IDX_ENTRY_13, 32'h00005A00);
	endtask : test_reset_values

	// Distinct field values in every entry, channel extremes in ten and thirteen; the upper half of the word must read back zero.
	task automatic test_write_fields();
		logic [5:0]  idx;
		logic [15:0] w;
		for (int i = 0; i < 4; i++) begin
			idx = sqe_pkg::IDX_ENTRY_10 + 6'(i);
			w = u_host.entry_word(1'(i), idx, 1'h0, 4'(15 - i * 5), 4'(i * 5));
			wr(idx, {16'hFFFF, w});
			rd_chk("entry_rw", idx, {16'h0000, w});
			exp_e[i] = w;
		end
	endtask : test_write_fields

	// A word carrying another entry's address must leave the target untouched.
	task automatic test_bad_address();
		logic [15:0] w;
		w = u_host.entry_word(1'h1, sqe_pkg::IDX_ENTRY_12, 1'h1, 4'h7, 4'h7);
		wr(sqe_pkg::IDX_ENTRY_11, {16'h0000, w});
		rd_chk("entry11_kept", sqe_pkg::IDX_ENTRY_11, {16'h0000, exp_e[1]});
		wr(6'h3F, 32'h0000FFFF);
		rd_chk("unmapped", 6'h3F, 32'h00000000);
	endtask : test_bad_address

	// Walk 10, 11, 12 with the return bit set in 12, then back to 10.
	task automatic test_walk();
		logic [15:0] w [3];
		w[0] = u_host.entry_word(1'h1, sqe_pkg::IDX_ENTRY_10, 1'h0, 4'h1, 4'h2);
		w[1] = u_host.entry_word(1'h0, sqe_pkg::IDX_ENTRY_11, 1'h0, 4'h3, 4'h4);
		w[2] = u_host.entry_word(1'h1, sqe_pkg::IDX_ENTRY_12, 1'h1, 4'h5, 4'h6);
		for (int i = 0; i < 3; i++) begin
			wr(sqe_pkg::IDX_ENTRY_10 + 6'(i), {16'h0000, w[i]});
		end
		@(posedge clk);
		conv_start <= 1'h1;
		@(posedge clk);
		conv_start <= 1'h0;
		#1;
		chk("start_disabled", 32'h0, {31'h0, seq_busy});
		wr(sqe_pkg::IDX_CONTROL, 32'h00000001);
		repeat (2) @(posedge clk);
		conv_step(w[0], 2'h0, 2'h1);
		conv_step(w[1], 2'h1, 2'h2);
		conv_step(w[2], 2'h2, 2'h0);
		conv_step(w[0], 2'h0, 2'h1);
		rd_chk("status_walk", sqe_pkg::IDX_STATUS, 32'h00000001);
		rd_chk("control_on", sqe_pkg::IDX_CONTROL, 32'h00000001);
		wr(sqe_pkg::IDX_CONTROL, 32'h00000000);
		rd_chk("status_off", sqe_pkg::IDX_STATUS, 32'h00000000);
	endtask : test_walk

	// ****************************************************************
	// Verdict and run control
	// ****************************************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		clk = 1'h0;
		resetn = 1'h0;
		conv_start = 1'h0;
		conv_done = 1'h0;
		fail_count = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		test_reset_values();
		test_write_fields();
		test_bad_address();
		test_walk();
		print_verdict();
	end

	// The scenarios need about a hundred cycles; 5000 cycles means a hang.
	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end

endmodule : testbench
